// ### ccr_combiner.sv
// Pad ring clock request combiner, purely combinational
`timescale 1ns/1ns
`default_nettype none
module ccr_combiner (
  input  wire logic               internal_awake,
  input  wire logic               ext_req,
  input  wire ccr_pkg::ccr_strap_type strap,
  output logic                    clk_req
);

  // Combine mode enables the external request; it is never inverted
  wire use_ext = strap.combine;                                    // RULE_05 RULE_06
  wire hi_form = internal_awake | (use_ext & ext_req);             // RULE_08
  wire lo_form = use_ext ? (ext_req & ~internal_awake)             // RULE_09
                         : ~internal_awake;                        // RULE_03

  // Output follows inputs with no clock involved
  assign clk_req = strap.polarity ? hi_form : lo_form;             // RULE_21 RULE_07 RULE_01

endmodule
`default_nettype wire

// ### ccr_far_side.sv
// Far side model: slow clock source, prescaled reference and system requester
`timescale 1ns/1ns
`default_nettype none
module ccr_far_side #(
  parameter int SLOW_HALF = 32,
  parameter int REF_DIV   = 5
) (
  input  wire logic aclk,
  input  wire logic req_want,
  output logic      slow_sleep_clock,
  output logic      ref_div_tick,
  output logic      ext_clk_req
);
  int   slow_cnt = 0;
  int   ref_cnt  = 0;
  logic slow_q   = 1'b0;
  // Slow clock free-running from power-up, steady through reset
  always @(posedge aclk) begin
    slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
    if (slow_cnt == SLOW_HALF - 1) slow_q <= ~slow_q;
    ref_cnt <= (ref_cnt == REF_DIV - 1) ? 0 : ref_cnt + 1;
  end
  assign slow_sleep_clock = slow_q;
  assign ref_div_tick     = (ref_cnt == 0);
  // Request already in output polarity, always driven
  assign ext_clk_req = req_want;
endmodule
`default_nettype wire

// ### ccr_pkg.sv
// Constants, types and register map for the clock request and reference select block
package ccr_pkg;

  // Clock and timing
  localparam int           CLK_HZ          = 25_000_000;
  localparam longint       SLOW_CLK_MHZ    = 32768;          // Slow sleep clock, Hz
  localparam int           ACC_BITS        = 32;
  // NCO step for the slow sleep clock derived from the main clock
  localparam logic [31:0]  NCO_STEP_NOM    =
    32'((SLOW_CLK_MHZ * (64'd1 << ACC_BITS)) / CLK_HZ);
  localparam logic [15:0]  DEFAULT_REF_KHZ = 16'd20000;

  // Frequency detection: reference prescaled by REF_PRESCALE, counted over DET_PERIODS
  localparam int           REF_PRESCALE    = 8;
  localparam int           DET_PERIODS     = 128;
  localparam int           DET_W           = 16;
  localparam int           NUM_STD         = 17;
  localparam logic [15:0]  STD_KHZ [NUM_STD] = '{
    16'd12000, 16'd13000, 16'd14400, 16'd15360, 16'd16200, 16'd16800,
    16'd18000, 16'd19200, 16'd19440, 16'd19680, 16'd19800, 16'd20000,
    16'd24000, 16'd26000, 16'd33600, 16'd37400, 16'd38400};
  localparam int           TOL_SHIFT       = 10;             // About 0.1 % window

  // Register byte offsets
  localparam logic [7:0]   OFS_CTRL        = 8'h00;
  localparam logic [7:0]   OFS_STATUS      = 8'h04;
  localparam logic [7:0]   OFS_REF_FREQ    = 8'h08;
  localparam logic [7:0]   OFS_TRIM        = 8'h0C;
  localparam logic [7:0]   OFS_SLEEP_TICKS = 8'h10;
  localparam logic [7:0]   OFS_DET_COUNT   = 8'h14;

  // Control register fields
  localparam int           CTRL_SLEEP_GO   = 0;
  localparam int           CTRL_GPIO_SEL   = 1;
  localparam int           CTRL_GPIO_VAL   = 2;
  localparam int           CTRL_SLOW_INT   = 3;

  // Reference frequency source codes
  localparam logic [1:0]   SRC_DEFAULT     = 2'h0;
  localparam logic [1:0]   SRC_NVRAM       = 2'h1;
  localparam logic [1:0]   SRC_DETECT      = 2'h2;

  // Reset values and bus answers
  localparam logic [15:0]  TRIM_RST        = 16'h0000;
  localparam logic [15:0]  SLEEP_TICKS_RST = 16'h0020;
  localparam logic [1:0]   RESP_OKAY       = 2'h0;
  localparam logic [1:0]   RESP_SLVERR     = 2'h2;

  typedef enum logic [1:0] {INIT_LOAD, INIT_DETECT, INIT_RUN} ccr_init_type;
  typedef enum logic       {PWR_AWAKE, PWR_SLEEP} ccr_pwr_type;

  // Strap levels as seen at the pads
  typedef struct packed {
    logic polarity;
    logic combine;
  } ccr_strap_type;

endpackage

// ### ccr_sleep_clock.sv
// Slow sleep clock tick source: external input or trimmed internal NCO
`timescale 1ns/1ns
`default_nettype none
module ccr_sleep_clock (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ext_level,
  input  wire logic        use_internal,
  input  wire logic [15:0] trim,
  output logic             ext_edge,
  output logic             tick
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic        carry_next;
  logic        ext_d_reg;
  logic        tick_reg;

  // Signed trim offsets the nominal step, fractional tuning
  wire [31:0] step = ccr_pkg::NCO_STEP_NOM + {{16{trim[15]}}, trim};  // RULE_16
  assign {carry_next, acc_next} = {1'b0, acc_reg} + {1'b0, step};      // RULE_19
  assign ext_edge = ext_level & ~ext_d_reg;

  // Accumulator, edge detector and tick select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg   <= '0;
      ext_d_reg <= 1'b0;
      tick_reg  <= 1'b0;
    end else begin
      acc_reg   <= acc_next;
      ext_d_reg <= ext_level;
      tick_reg  <= use_internal ? carry_next : ext_edge;            // RULE_02 RULE_18
    end
  end

  assign tick = tick_reg;

endmodule
`default_nettype wire

// ### ccr_top.sv
// Clock request generation, reference frequency selection and sleep timing
// What this block does
// RULE_01: Clock request asserted while awake, deasserted while asleep.
// RULE_02: Sleep timing uses slow sleep clock, external or internal.
// RULE_03: Polarity strap 0 gives active low output, 1 active high.
// RULE_04: Unused clock request pad can serve as general-purpose output.
// RULE_05: Combine strap high makes second pad the external request input.
// RULE_06: Without combine strap, output uses internal need only.
// RULE_07: Combining works whenever pad supply is present, core asleep or off.
// RULE_08: Polarity 1: output is external request OR internal awake.
// RULE_09: Polarity 0: output high only when external is 1 and internal sleeps.
// RULE_10: External requester presents request already in output polarity.
// RULE_11: Packages without polarity ball use an internally fixed strap.
// RULE_12: Reference frequency is default 20 MHz, non-volatile value, or detected.
// RULE_13: At power-on reset, settings load from external non-volatile memory.
// RULE_14: Standard reference frequencies are detected and configured automatically.
// RULE_15: System supplies stable external slow clock during power-on reset.
// RULE_16: Digital fractional trim tunes reference to two ppm.
// RULE_17: Trim comes from host command write or non-volatile load.
// RULE_18: Park, hold and sniff timing use the slow sleep clock.
// RULE_19: Slow sleep clock may be derived internally from main clock.
// RULE_20: System always drives external request input, never floating.
// RULE_21: Combining path is combinational, independent of any core clock.
`timescale 1ns/1ns
`default_nettype none
module ccr_top #(
  parameter bit STRAP_BONDED   = 1'b1,
  parameter bit FIXED_POLARITY = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        polarity_strap,
  input  wire logic        combine_mode_strap,
  input  wire logic        ext_clk_req,
  input  wire logic        slow_sleep_clock,
  input  wire logic        ref_div_tick,
  input  wire logic        wake_event,
  input  wire logic        nv_done,
  input  wire logic        nv_freq_valid,
  input  wire logic [15:0] nv_freq_khz,
  input  wire logic        nv_trim_valid,
  input  wire logic [15:0] nv_trim,
  output logic             clk_req_pad_o,
  output logic             clk_req_pad_oe,
  output logic             slow_tick
);

  localparam int DW = ccr_pkg::DET_W;

  ccr_pkg::ccr_init_type   init_reg;
  ccr_pkg::ccr_pwr_type    pwr_reg;
  ccr_pkg::ccr_strap_type  strap;
  logic                    gpio_sel_reg;
  logic                    gpio_val_reg;
  logic                    slow_int_reg;
  logic [15:0]             trim_reg;
  logic [15:0]             sleep_ticks_reg;
  logic [15:0]             sleep_cnt_reg;
  logic [15:0]             ref_khz_reg;
  logic [1:0]              ref_src_reg;
  logic                    nv_loaded_reg;
  logic                    det_ok_reg;
  logic [7:0]              det_periods_reg;
  logic [DW-1:0]           det_cnt_reg;
  logic [DW-1:0]           det_result_reg;
  logic                    bvalid_reg;
  logic [1:0]              bresp_reg;
  logic                    rvalid_reg;
  logic [1:0]              rresp_reg;
  logic [31:0]             rdata_reg;
  logic                    ext_edge;
  logic                    tick;
  logic                    combined_req;

  // Expected prescaled count for a standard frequency over the window
  function automatic logic [DW-1:0] expect_cnt(input logic [15:0] khz);
    logic [63:0] v;
    // Wide product: the top standard frequencies overflow 32 bits
    v = (64'(khz) * 64'd1000 * 64'(ccr_pkg::DET_PERIODS))
        / (64'(ccr_pkg::REF_PRESCALE) * 64'(ccr_pkg::SLOW_CLK_MHZ));
    return v[DW-1:0];
  endfunction

  // Last standard frequency in table order inside tolerance, zero when none matches
  function automatic logic [15:0] match_khz(input logic [DW-1:0] cnt);
    logic [15:0]   best;
    logic [DW-1:0] e;
    logic [DW-1:0] d;
    best = '0;
    for (int i = 0; i < ccr_pkg::NUM_STD; i++) begin
      e = expect_cnt(ccr_pkg::STD_KHZ[i]);
      d = (cnt > e) ? cnt - e : e - cnt;
      if (d <= (e >> ccr_pkg::TOL_SHIFT) + DW'(1)) begin
        best = ccr_pkg::STD_KHZ[i];
      end
    end
    return best;
  endfunction

  // Straps: fixed polarity where the ball is not bonded out
  assign strap.polarity = STRAP_BONDED ? polarity_strap : FIXED_POLARITY;  // RULE_11
  assign strap.combine  = combine_mode_strap;                              // RULE_05

  // Pad ring combiner, independent of aclk
  ccr_combiner u_comb (
    .internal_awake (pwr_reg == ccr_pkg::PWR_AWAKE),
    .ext_req        (ext_clk_req),                                   // RULE_10 RULE_20
    .strap          (strap),
    .clk_req        (combined_req)
  );

  // Slow sleep clock source with trimmed internal NCO
  ccr_sleep_clock u_slow (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .ext_level    (slow_sleep_clock),
    .use_internal (slow_int_reg),
    .trim         (trim_reg),
    .ext_edge     (ext_edge),
    .tick         (tick)
  );

  // Pad drive: clock request or general-purpose level
  assign clk_req_pad_o  = gpio_sel_reg ? gpio_val_reg : combined_req;  // RULE_04 RULE_07
  assign clk_req_pad_oe = 1'b1;
  assign slow_tick      = tick;

  // Bus decode
  wire        wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  wire        rd_go   = s_axi_arvalid & ~rvalid_reg;
  wire [7:0]  wa      = s_axi_awaddr;
  wire [7:0]  ra      = s_axi_araddr;
  wire        wr_ctrl = wr_go & (wa == ccr_pkg::OFS_CTRL);
  wire        wr_trim = wr_go & (wa == ccr_pkg::OFS_TRIM);
  wire        wr_slp  = wr_go & (wa == ccr_pkg::OFS_SLEEP_TICKS);
  wire        wr_ok   = wr_ctrl | wr_trim | wr_slp | (wa == ccr_pkg::OFS_STATUS)
                        | (wa == ccr_pkg::OFS_REF_FREQ) | (wa == ccr_pkg::OFS_DET_COUNT);
  wire [15:0] wlo     = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : trim_reg[15:8],
                         s_axi_wstrb[0] ? s_axi_wdata[7:0]  : trim_reg[7:0]};
  wire [15:0] wslp    = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : sleep_ticks_reg[15:8],
                         s_axi_wstrb[0] ? s_axi_wdata[7:0]  : sleep_ticks_reg[7:0]};
  wire        ctrl_b0 = wr_ctrl & s_axi_wstrb[0];
  wire        sleep_go = ctrl_b0 & s_axi_wdata[ccr_pkg::CTRL_SLEEP_GO];

  wire [31:0] status_word = {25'h0, ref_src_reg, det_ok_reg, nv_loaded_reg,
                             strap.combine, strap.polarity, pwr_reg == ccr_pkg::PWR_AWAKE};
  wire [31:0] ctrl_word   = {28'h0, slow_int_reg, gpio_val_reg, gpio_sel_reg, 1'b0};
  wire        rd_hit      = (ra == ccr_pkg::OFS_CTRL) | (ra == ccr_pkg::OFS_STATUS)
                            | (ra == ccr_pkg::OFS_REF_FREQ) | (ra == ccr_pkg::OFS_TRIM)
                            | (ra == ccr_pkg::OFS_SLEEP_TICKS)
                            | (ra == ccr_pkg::OFS_DET_COUNT);
  wire [31:0] rd_word =
    (ra == ccr_pkg::OFS_CTRL)        ? ctrl_word :
    (ra == ccr_pkg::OFS_STATUS)      ? status_word :
    (ra == ccr_pkg::OFS_REF_FREQ)    ? {16'h0, ref_khz_reg} :
    (ra == ccr_pkg::OFS_TRIM)        ? {16'h0, trim_reg} :
    (ra == ccr_pkg::OFS_SLEEP_TICKS) ? {16'h0, sleep_ticks_reg} :
    (ra == ccr_pkg::OFS_DET_COUNT)   ? {{(32-DW){1'b0}}, det_result_reg} : 32'h0;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = rd_go;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;

  // Bus responses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ccr_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= ccr_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0;
    end else begin
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        rvalid_reg <= 1'b1;
        rresp_reg  <= rd_hit ? ccr_pkg::RESP_OKAY : ccr_pkg::RESP_SLVERR;
        rdata_reg  <= rd_word;
      end else if (s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // Software-owned control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_sel_reg    <= 1'b0;
      gpio_val_reg    <= 1'b0;
      slow_int_reg    <= 1'b0;
      sleep_ticks_reg <= ccr_pkg::SLEEP_TICKS_RST;
    end else begin
      if (ctrl_b0) begin
        gpio_sel_reg <= s_axi_wdata[ccr_pkg::CTRL_GPIO_SEL];              // RULE_04
        gpio_val_reg <= s_axi_wdata[ccr_pkg::CTRL_GPIO_VAL];
        slow_int_reg <= s_axi_wdata[ccr_pkg::CTRL_SLOW_INT];              // RULE_19
      end
      if (wr_slp) begin
        sleep_ticks_reg <= wslp;
      end
    end
  end

  // Trim: loaded at power-on, overwritten by host command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trim_reg <= ccr_pkg::TRIM_RST;
    end else if (wr_trim) begin
      trim_reg <= wlo;                                                    // RULE_17
    end else if (init_reg == ccr_pkg::INIT_LOAD && nv_done && nv_trim_valid) begin
      trim_reg <= nv_trim;                                                // RULE_13 RULE_17
    end
  end

  wire det_window_end = ext_edge && (det_periods_reg == 8'(ccr_pkg::DET_PERIODS));
  wire [15:0] det_khz = match_khz(det_cnt_reg);

  // Power-on sequence: load settings, then detect if needed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_reg        <= ccr_pkg::INIT_LOAD;
      ref_khz_reg     <= ccr_pkg::DEFAULT_REF_KHZ;
      ref_src_reg     <= ccr_pkg::SRC_DEFAULT;
      nv_loaded_reg   <= 1'b0;
      det_ok_reg      <= 1'b0;
      det_periods_reg <= 8'h00;
      det_cnt_reg     <= '0;
      det_result_reg  <= '0;
    end else begin
      unique case (init_reg)
        ccr_pkg::INIT_LOAD: begin
          if (nv_done) begin
            nv_loaded_reg <= 1'b1;                                        // RULE_13
            if (nv_freq_valid) begin
              ref_khz_reg <= nv_freq_khz;                                 // RULE_12
              ref_src_reg <= ccr_pkg::SRC_NVRAM;
              init_reg    <= ccr_pkg::INIT_RUN;
            end else begin
              init_reg    <= ccr_pkg::INIT_DETECT;
            end
          end
        end
        ccr_pkg::INIT_DETECT: begin
          // Count prescaled reference between external slow clock edges
          if (ext_edge) begin                                             // RULE_15
            det_periods_reg <= det_periods_reg + 8'h01;
          end
          if (det_periods_reg != 8'h00 && ref_div_tick) begin
            det_cnt_reg <= det_cnt_reg + DW'(1);
          end
          if (det_window_end) begin
            det_result_reg <= det_cnt_reg;
            init_reg       <= ccr_pkg::INIT_RUN;
            if (det_khz != 16'h0) begin
              ref_khz_reg <= det_khz;                                     // RULE_14 RULE_12
              ref_src_reg <= ccr_pkg::SRC_DETECT;
              det_ok_reg  <= 1'b1;
            end
          end
        end
        ccr_pkg::INIT_RUN: begin
        end
      endcase
    end
  end

  // Awake and sleep states timed by slow sleep clock ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_reg       <= ccr_pkg::PWR_AWAKE;
      sleep_cnt_reg <= 16'h0;
    end else begin
      unique case (pwr_reg)
        ccr_pkg::PWR_AWAKE: begin
          if (sleep_go && init_reg == ccr_pkg::INIT_RUN) begin
            pwr_reg       <= ccr_pkg::PWR_SLEEP;                          // RULE_01
            sleep_cnt_reg <= sleep_ticks_reg;
          end
        end
        ccr_pkg::PWR_SLEEP: begin
          if (tick && sleep_cnt_reg != 16'h0) begin
            sleep_cnt_reg <= sleep_cnt_reg - 16'h1;                       // RULE_18 RULE_02
          end
          if (wake_event || (tick && sleep_cnt_reg <= 16'h1)) begin
            pwr_reg <= ccr_pkg::PWR_AWAKE;                                // RULE_01
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### ccr_top_checker.sv
// Port-level assertions for the clock request and reference select block
`timescale 1ns/1ns
`default_nettype none
module ccr_top_checker #(
  parameter bit STRAP_BONDED   = 1'b1,
  parameter bit FIXED_POLARITY = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic        s_axi_arvalid,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        polarity_strap,
  input  wire logic        combine_mode_strap,
  input  wire logic        ext_clk_req,
  input  wire logic        clk_req_pad_o,
  input  wire logic        clk_req_pad_oe
);
  logic gsel_reg;
  logic gval_reg;
  wire  pol    = STRAP_BONDED ? polarity_strap : FIXED_POLARITY;
  wire  w_take = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  wire  c_wr   = w_take && s_axi_awaddr == ccr_pkg::OFS_CTRL && s_axi_wstrb[0];
  // Shadow of the pad ownership bits seen on the bus
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gsel_reg <= 1'b0;
      gval_reg <= 1'b0;
    end else if (c_wr) begin
      gsel_reg <= s_axi_wdata[ccr_pkg::CTRL_GPIO_SEL];
      gval_reg <= s_axi_wdata[ccr_pkg::CTRL_GPIO_VAL];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wtake;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && !s_axi_rvalid;
  endsequence
  // Bus handshake
  a_write_ready: assert property (s_axi_awready == w_take && s_axi_wready == w_take)
    else $error("write ready wrong");
  a_write_answer: assert property (s_wtake |=> s_axi_bvalid) else $error("no write answer");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_answer: assert property (s_rtake |=> s_axi_rvalid) else $error("no read answer");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  // Pad relations
  a_pad_driven: assert property (clk_req_pad_oe) else $error("pad not driven");
  a_pol_high_or: assert property (!gsel_reg && pol && combine_mode_strap && ext_clk_req
    |-> clk_req_pad_o) else $error("or path wrong");
  a_pol_low_and: assert property (!gsel_reg && !pol && combine_mode_strap && !ext_clk_req
    |-> !clk_req_pad_o) else $error("and path wrong");
  a_pad_as_gpio: assert property (gsel_reg |-> clk_req_pad_o == gval_reg)
    else $error("gpio level wrong");
  a_reset_awake: assert property (!$past(aresetn) |-> clk_req_pad_o == pol)
    else $error("not awake after reset");
endmodule
bind ccr_top ccr_top_checker #(.STRAP_BONDED(STRAP_BONDED), .FIXED_POLARITY(FIXED_POLARITY))
  u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .polarity_strap, .combine_mode_strap,
  .ext_clk_req, .clk_req_pad_o, .clk_req_pad_oe);
`default_nettype wire

// ### tb_clock_request_refclk_select.sv
// Self-checking bench for the clock request and reference select block
`timescale 1ns/1ns
`default_nettype none
module tb_clock_request_refclk_select;
  logic        aclk = 1'b0, aresetn = 1'b0, wake = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, t;
  logic        awready, wready, bvalid, arready, rvalid, pad, pad_oe, tick, ext, slow, rtk;
  logic [1:0]  bresp, rresp;
  logic        pol = 1'b1, comb = 1'b0, want = 1'b0, nvv = 1'b1;
  logic [15:0] lfsr = 16'h000A;
  int          error_cnt = 0, n_compared = 0, sleep_ticks = 0, all_ticks = 0;
  int          aw = 1, gs = 0, gv = 0;
  always #20 aclk = ~aclk;
  ccr_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .polarity_strap(pol), .combine_mode_strap(comb), .ext_clk_req(ext),
    .slow_sleep_clock(slow), .ref_div_tick(rtk), .wake_event(wake), .nv_done(1'b1),
    .nv_freq_valid(nvv), .nv_freq_khz(16'd26000), .nv_trim_valid(1'b1), .nv_trim(16'h0123),
    .clk_req_pad_o(pad), .clk_req_pad_oe(pad_oe), .slow_tick(tick));
  ccr_far_side u_far (.aclk(aclk), .req_want(want), .slow_sleep_clock(slow),
    .ref_div_tick(rtk), .ext_clk_req(ext));
  // Tick counters
  always @(posedge aclk) begin
    if (tick === 1'b1) all_ticks++;
    if (tick === 1'b1 && pad === 1'b0) sleep_ticks++;
  end
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Pad model from strap, request and awake state
  function automatic logic mpad();
    if (gs != 0) return gv != 0;
    if (pol) return aw != 0 || (comb && want);
    return comb ? want && aw == 0 : aw == 0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (awready !== 1'b1) @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    @(posedge aclk);
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    check(32'(bresp), 32'(er));
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    check(rdata, ed);
    check(32'(rresp), 32'(er));
    @(posedge aclk);
  endtask
  // Every strap and request combination against the model
  task automatic combos();
    for (int i = 0; i < 8; i++) begin
      {pol, comb, want} <= 3'(i);
      @(posedge aclk);
      check(32'(pad), 32'(mpad()));
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h08, 32'd26000, 2'h0);
    rd(8'h0C, 32'h0000_0123, 2'h0);
    rd(8'h04, 32'h0000_002B, 2'h0);
    rd(8'h10, 32'h0000_0020, 2'h0);
    rd(8'h18, 32'h0000_0000, 2'h2);
    wr(8'h08, 32'h0000_0001, 2'h0);
    rd(8'h08, 32'd26000, 2'h0);
    t = {16'h0, rnd()};
    wr(8'h0C, t, 2'h0);
    rd(8'h0C, t, 2'h0);
    $display("test registers done");
    combos();
    $display("test awake pad done");
    wr(8'h10, 32'h0000_FFFF, 2'h0);
    wr(8'h00, 32'h0000_0001, 2'h0);
    aw = 0;
    combos();
    rd(8'h04, 32'h0000_002E, 2'h0);
    for (int i = 0; i < 8; i++) begin
      {pol, comb, want} <= 3'(rnd());
      @(posedge aclk);
      check(32'(pad), 32'(mpad()));
    end
    {pol, comb, want} <= 3'b110;
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    repeat (2) @(posedge aclk);
    aw = 1;
    rd(8'h04, 32'h0000_002F, 2'h0);
    $display("test sleep pad done");
    {pol, comb, want} <= 3'b100;
    wr(8'h10, 32'h0000_0003, 2'h0);
    sleep_ticks = 0;
    wr(8'h00, 32'h0000_0001, 2'h0);
    for (int n = 0; n < 3000 && pad !== 1'b1; n++) @(posedge aclk);
    check(sleep_ticks, 3);
    $display("test sleep ticks done");
    for (int v = 6; v >= 2; v -= 4) begin
      wr(8'h00, 32'(v), 2'h0);
      gs = 1;
      gv = v >> 2;
      check(32'(pad), 32'(mpad()));
    end
    wr(8'h00, 32'h0000_0000, 2'h0);
    gs = 0;
    all_ticks = 0;
    repeat (640) @(posedge aclk);
    check(32'(all_ticks >= 9 && all_ticks <= 11), 1);
    wr(8'h00, 32'h0000_0008, 2'h0);
    all_ticks = 0;
    repeat (7630) @(posedge aclk);
    check(32'(all_ticks >= 9 && all_ticks <= 11), 1);
    $display("test gpio and slow clock done");
    // Mid-run reset without a stored frequency: detection finds no standard value
    aresetn <= 1'b0;
    nvv <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8400) @(posedge aclk);
    rd(8'h08, 32'd20000, 2'h0);
    rd(8'h04, 32'h0000_000B, 2'h0);
    rd(8'h0C, 32'h0000_0123, 2'h0);
    $display("test detect after reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
